// ===== dv/fsq_array_model.sv
// Array engine model: ends each program request after a set delay.
// Assumes the bench sets the delay and the lock switch.
`timescale 1ns/100ps
module fsq_array_model (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic       prog_req_in,
  input  wire logic [7:0] delay_in,
  input  wire logic       lock_on_in,
  input  wire logic [6:0] block_in,
  output logic            done_out,
  output logic            fail_out,
  output logic            locked_out,
  output logic [15:0]     array_out,
  output logic [15:0]     aux_out
);
  logic [7:0] cnt_r;
  assign fail_out   = 1'b0;
  assign array_out  = 16'ha5c3;
  assign aux_out    = 16'h3c5a;
  // Only block 0ah can be locked
  assign locked_out = lock_on_in && block_in == 7'h0a;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r    <= '0;
      done_out <= 1'b0;
    end else begin
      done_out <= prog_req_in && !done_out && cnt_r == delay_in;
      cnt_r    <= (prog_req_in && !done_out && cnt_r != delay_in) ? cnt_r + 8'h01 : '0;
    end
  end
endmodule

// ===== dv/fsq_asserts.sv
// Port checker for the program sequencer, bound to the design module.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/100ps
module fsq_asserts (
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  input wire logic        wr_valid_in,
  input wire logic [15:0] wr_data_in,
  input wire logic        rd_valid_in,
  input wire logic        rd_valid_out,
  input wire logic        reset_pin_low_active_in,
  input wire logic        prog_valid_out,
  input wire logic        prog_done_in,
  input wire logic        prog_fail_in,
  input wire logic [7:0]  status_out,
  input wire logic        busy_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // ----------
  // Helpers
  // ----------
  logic [3:0] pin_r;
  logic       clr_r;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_r <= 4'hf;
      clr_r <= 1'b0;
    end else begin
      pin_r <= {pin_r[2:0], reset_pin_low_active_in};
      // Ignored clears also count; weaker but never false
      if ((wr_valid_in && wr_data_in[7:0] == 8'h50) || !reset_pin_low_active_in)
        clr_r <= 1'b1;
      else if ($fell(status_out[4]))
        clr_r <= 1'b0;
    end
  end
  sequence word_done;
    prog_valid_out && prog_done_in && !prog_fail_in;
  endsequence
  sequence pin_held;
    !reset_pin_low_active_in [*6];
  endsequence
  // ----------
  // Properties
  // ----------
  a_read_answer: assert property (rd_valid_in |=> rd_valid_out)
    else $error("read not answered");
  a_prog_stands: assert property (prog_valid_out && !prog_done_in && pin_r == 4'hf
    |=> prog_valid_out) else $error("request dropped early");
  a_done_drops: assert property (word_done |=> !prog_valid_out)
    else $error("request held after done");
  a_ready_low: assert property (prog_valid_out |-> !status_out[7])
    else $error("ready while programming");
  a_busy_prog: assert property (prog_valid_out |-> busy_out)
    else $error("not busy while programming");
  a_pin_abort: assert property (pin_held |-> !prog_valid_out && !busy_out)
    else $error("pin abort missed");
  a_err_sticky: assert property ($fell(status_out[4]) |-> clr_r)
    else $error("error bit fell unasked");
  a_err_both: assert property ($rose(status_out[5]) |-> status_out[4])
    else $error("erase error alone");
endmodule

bind flash_word_buffer_program_sequencer fsq_asserts u_fsq_asserts (
  .sys_clk_in             (sys_clk_in),
  .rst_in                 (rst_in),
  .wr_valid_in            (wr_valid_in),
  .wr_data_in             (wr_data_in),
  .rd_valid_in            (rd_valid_in),
  .rd_valid_out           (rd_valid_out),
  .reset_pin_low_active_in(reset_pin_low_active_in),
  .prog_valid_out         (prog_valid_out),
  .prog_done_in           (prog_done_in),
  .prog_fail_in           (prog_fail_in),
  .status_out             (status_out),
  .busy_out               (busy_out)
);

// ===== dv/tb.sv
// Bench for the program sequencer: program, buffer, errors, abort.
// Assumes the array model on the far side of the program port.
`timescale 1ns/100ps
module tb;
  logic        clk = 1'b0, rst = 1'b1, wv = 1'b0, rv = 1'b0, rp = 1'b1, lk = 1'b0, hv = 1'b0;
  logic [22:0] wa = '0, ra = '0, padr;
  logic [15:0] wd = '0, arr, aux, rdat, pdat, d;
  logic [7:0]  dly = 8'h20, st;
  logic [6:0]  blk;
  logic        wrdy, rvo, pv, slow, done, fl, lkd, busy;
  logic [15:0] rows [3][2] = '{'{16'h00ff, 16'ha5c3}, '{16'h0090, 16'h3c5a},
                               '{16'h0070, 16'h0081}};
  int          fail_count = 0, checks = 0;
  localparam logic [22:0] A = 23'h0a0010;
  localparam logic [22:0] S = 23'h0a0021;
  localparam logic [22:0] F = 23'h0a0020;
  always #5 clk = ~clk;
  flash_word_buffer_program_sequencer u_flash_word_buffer_program_sequencer (
    .sys_clk_in(clk), .rst_in(rst), .wr_valid_in(wv), .wr_addr_in(wa), .wr_data_in(wd),
    .wr_ready_out(wrdy), .rd_valid_in(rv), .rd_addr_in(ra), .array_data_in(arr),
    .aux_data_in(aux), .rd_valid_out(rvo), .rd_data_out(rdat),
    .reset_pin_low_active_in(rp), .high_program_supply_level_in(hv),
    .block_locked_in(lkd), .lock_block_out(blk), .prog_valid_out(pv),
    .prog_addr_out(padr), .prog_data_out(pdat), .prog_slow_out(slow),
    .prog_done_in(done), .prog_fail_in(fl), .status_out(st), .busy_out(busy));
  fsq_array_model u_fsq_array_model (
    .sys_clk_in(clk), .rst_in(rst), .prog_req_in(pv), .delay_in(dly), .lock_on_in(lk),
    .block_in(blk), .done_out(done), .fail_out(fl), .locked_out(lkd), .array_out(arr),
    .aux_out(aux));
  // ----------
  // Tasks
  // ----------
  task automatic end_of_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [22:0] e, input logic [22:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [22:0] a, input logic [15:0] v);
    @(posedge clk);
    wv <= 1'b1;
    wa <= a;
    wd <= v;
    @(posedge clk);
    wv <= 1'b0;
  endtask
  task automatic rd(input logic [22:0] a);
    @(posedge clk);
    rv <= 1'b1;
    ra <= a;
    @(posedge clk);
    rv <= 1'b0;
    #1;
    chk("rd_valid", 1, rvo);
    d = rdat;
  endtask
  task automatic wait_pv(input logic v);
    for (int i = 0; i < 400 && pv !== v; i++) cyc(1);
    chk("prog_valid", v, pv);
    if (pv !== v) end_of_test();
  endtask
  // Buffered load of count n then n+1 words and confirm
  task automatic bufp(input logic [22:0] c, input int n);
    wr(S, 16'h00e8);
    wr(c, 16'(n));
    for (int k = 0; k <= n; k++) wr(S + 23'(k), 16'h1111 * 16'(k + 1));
    wr(S, 16'h00d0);
  endtask
  // ----------
  // Sequence
  // ----------
  initial begin
    cyc(10);
    chk("reset_status", 8'h81, st);
    chk("reset_ready", 0, wrdy);
    rst <= 1'b0;
    cyc(2);
    wr(A, 16'h0040);
    wr(A, 16'h1234);
    wait_pv(1);
    chk("prog_addr", A, padr);
    chk("prog_data", 16'h1234, pdat);
    wr(A, 16'h0050);
    cyc(4);
    rd(A);
    chk("busy_read", 0, d[15:7]);
    wait_pv(0);
    chk("ready_done", 1, st[7]);
    for (int i = 0; i < 3; i++) begin
      wr(A, rows[i][0]);
      cyc(4);
      rd(A);
      chk("read_mode", rows[i][1], d);
    end
    dly <= 8'h04;
    bufp(S, 1);
    for (int k = 0; k < 2; k++) begin
      wait_pv(1);
      chk("buf_addr", S + 23'(k), padr);
      chk("buf_data", 16'h1111 * 16'(k + 1), pdat);
      chk("slow", 1, slow);
      wait_pv(0);
    end
    wr(S, 16'h00e8);
    wr(23'h0b0021, 16'h0001);
    cyc(4);
    chk("span_err", 2'b11, st[5:4]);
    bufp(S, 0);
    cyc(8);
    chk("refused", 0, pv);
    chk("sticky", 2'b11, st[5:4]);
    wr(S, 16'h0050);
    cyc(4);
    chk("cleared", 0, st[5:4]);
    lk <= 1'b1;
    bufp(S, 0);
    cyc(4);
    chk("protect", 2'b11, {st[4], st[1]});
    chk("no_prog", 0, pv);
    lk <= 1'b0;
    wr(S, 16'h0050);
    wr(A, 16'h0080);
    wr(A, 16'h00d0);
    cyc(4);
    chk("factory_err", 2'b01, st[5:4]);
    wr(A, 16'h0050);
    dly <= 8'hff;
    wr(A, 16'h0040);
    wr(A, 16'h4321);
    wait_pv(1);
    rp <= 1'b0;
    cyc(7);
    chk("abort_prog", 0, pv);
    chk("abort_busy", 0, busy);
    rp <= 1'b1;
    cyc(4);
    // Factory run on an aligned start with the high supply present
    hv <= 1'b1;
    dly <= 8'h01;
    wr(F, 16'h0080);
    wr(F, 16'h00d0);
    cyc(4);
    chk("fact_ready", 2'b11, {st[7], st[0]});
    for (int k = 0; k < 32; k++) wr(F, 16'(k));
    for (int k = 0; k < 2; k++) begin
      wait_pv(1);
      chk("fact_addr", F + 23'(k), padr);
      chk("fact_data", 16'(k), pdat);
      wait_pv(0);
    end
    chk("fact_busy", 1, busy);
    wr(23'h0b0000, 16'h00ff);
    for (int i = 0; i < 400 && busy; i++) cyc(1);
    chk("fact_exit", 8'h81, st);
    end_of_test();
  end
endmodule

// ===== rtl/flash_word_buffer_program_sequencer.sv
// Program command sequencer of a multi-bank NOR flash: single word,
// buffered and factory buffered programming, status and read modes.
// Assumes host writes and reads arrive as one-cycle strobes on this clock,
// an array engine that answers each word with done/fail, and lock/aux logic.
//
// Notes on behaviour
// - Single program: setup write, then address/data write
// - Programming bank reads return the status word
// - Busy bank takes only read modes and suspend; suspend is taken but has no effect
// - Reset pin low aborts programming
// - Write buffer holds up to 32 words
// - Buffer setup anywhere in block; ready bit gates
// - Count n means n+1 words follow
// - Unaligned buffer start doubles programming time
// - Span, sequence or protection errors abort cleanly
// - Both error bits set refuses buffer program
// - Busy bank during buffer program filters commands
// - Factory mode: one unlocked block, aligned buffers
// - Factory mode blocks other banks and suspend
// - Factory setup plus confirm; then status reads
// - Factory setup error sets program error, terminates
// - Factory load fills 32 words sequentially
// - Device advances address; out-of-block write exits
// - Full buffer programs, verifies, reprograms failures
// - Factory phase repeats until out-of-block write
// - Factory exit sets ready, bank shows status
// - Command 80h opens factory programming
// - Command D0h confirms a buffered program
// - Error bits stick until clear-status command or reset pin low
`timescale 1ns/100ps
`include "fsq_consts.svh"

module flash_word_buffer_program_sequencer
  import fsq_pkg::*;
#(
  parameter int INTAKE_DEPTH = `INTAKE_DEPTH,
  parameter int BUF_WORDS    = `BUF_WORDS
) (
  input  wire logic                   sys_clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   wr_valid_in,
  input  wire logic [`ADDR_W-1:0]     wr_addr_in,
  input  wire logic [`DATA_W-1:0]     wr_data_in,
  output logic                        wr_ready_out,
  input  wire logic                   rd_valid_in,
  input  wire logic [`ADDR_W-1:0]     rd_addr_in,
  input  wire logic [`DATA_W-1:0]     array_data_in,
  input  wire logic [`DATA_W-1:0]     aux_data_in,
  output logic                        rd_valid_out,
  output logic [`DATA_W-1:0]          rd_data_out,
  input  wire logic                   reset_pin_low_active_in,
  input  wire logic                   high_program_supply_level_in,
  input  wire logic                   block_locked_in,
  output logic [`BLOCK_HI-`BLOCK_LO:0] lock_block_out,
  output logic                        prog_valid_out,
  output logic [`ADDR_W-1:0]          prog_addr_out,
  output logic [`DATA_W-1:0]          prog_data_out,
  output logic                        prog_slow_out,
  input  wire logic                   prog_done_in,
  input  wire logic                   prog_fail_in,
  output logic [7:0]                  status_out,
  output logic                        busy_out
);

  // ----------------------------------------------------------------
  // Intake queue and write buffer
  // ----------------------------------------------------------------
  localparam int HW = $bits(host_write_t);

  host_write_t cmd;
  host_write_t buf_out;
  host_write_t buf_word;
  logic        cmd_valid;
  logic        take;
  logic        buf_push;
  logic        buf_pop;
  logic        buf_flush;
  logic        buf_valid;
  logic        buf_ready;

  // Intake queues host writes while factory words are being programmed; it stalls the host only in reset and once full
  word_fifo #(.WIDTH(HW), .DEPTH(INTAKE_DEPTH)) intake (
    .sys_clk_in   (sys_clk_in),
    .rst_in       (rst_in),
    .flush_in     (1'b0),
    .in_valid_in  (wr_valid_in),
    .in_data_in   ({wr_addr_in, wr_data_in}),
    .in_ready_out (wr_ready_out),
    .out_valid_out(cmd_valid),
    .out_data_out (cmd),
    .out_ready_in (take)
  );

  word_fifo #(.WIDTH(HW), .DEPTH(BUF_WORDS)) wbuf (
    .sys_clk_in   (sys_clk_in),
    .rst_in       (rst_in),
    .flush_in     (buf_flush),
    .in_valid_in  (buf_push),
    .in_data_in   (buf_word),
    .in_ready_out (buf_ready),
    .out_valid_out(buf_valid),
    .out_data_out (buf_out),
    .out_ready_in (buf_pop)
  );

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  seq_regs_t q_r;
  seq_regs_t q_nxt;

  logic [7:0]                   code;
  logic [`BLOCK_HI-`BLOCK_LO:0] cmd_blk;
  logic [`ADDR_W-1:0]           offs;
  logic                         engaged;
  logic                         rd_cmd;

  assign code    = cmd.data[7:0];
  assign cmd_blk = cmd.addr[`BLOCK_HI:`BLOCK_LO];
  assign offs    = cmd.addr - q_r.start;
  assign engaged = (q_r.state == S_RUN) || (q_r.state == S_WAIT);
  assign rd_cmd  = (code == `CMD_RD_ARRAY) || (code == `CMD_RD_STATUS) ||
                   (code == `CMD_RD_SIG) || (code == `CMD_RD_QUERY) ||
                   (code == `CMD_SUSPEND);

  // Factory programming holds host words back until the buffer drains
  assign take = cmd_valid && !(engaged && q_r.op == OP_FACTORY);

  always_comb begin
    q_nxt     = q_r;
    buf_push  = 1'b0;
    buf_pop   = 1'b0;
    buf_flush = 1'b0;
    buf_word  = cmd;

    // Read path: each bank answers in its own read mode
    q_nxt.rd_valid = rd_valid_in;
    unique case (q_r.modes[rd_addr_in[`BANK_HI:`BANK_LO]])
      MODE_ARRAY:  q_nxt.rd_data = array_data_in;
      MODE_STATUS: q_nxt.rd_data = {8'h00, q_r.stat_o};
      MODE_AUX:    q_nxt.rd_data = aux_data_in;
      default:     q_nxt.rd_data = array_data_in;
    endcase

    // ----------------------------------------------------------------
    // Host writes
    // ----------------------------------------------------------------
    if (take) begin
      unique case (q_r.state)
        S_IDLE: begin
          unique case (code)
            `CMD_RD_ARRAY:  q_nxt.modes[cmd.addr[`BANK_HI:`BANK_LO]] = MODE_ARRAY;
            `CMD_RD_STATUS: q_nxt.modes[cmd.addr[`BANK_HI:`BANK_LO]] = MODE_STATUS;
            `CMD_RD_SIG,
            `CMD_RD_QUERY:  q_nxt.modes[cmd.addr[`BANK_HI:`BANK_LO]] = MODE_AUX;
            `CMD_CLR_STATUS: begin
              q_nxt.err = '0;
            end
            `CMD_PROG_SETUP: begin
              q_nxt.state = S_PG_DATA;
            end
            `CMD_BUF_PROG: begin
              q_nxt.modes[cmd.addr[`BANK_HI:`BANK_LO]] = MODE_STATUS;
              if (!(q_r.err[`SR_PROG_ERR] && q_r.err[`SR_ERASE_ERR])) begin
                q_nxt.start     = cmd.addr;
                q_nxt.busy_bank = cmd.addr[`BANK_HI:`BANK_LO];
                q_nxt.state     = S_BP_COUNT;
              end
            end
            `CMD_FACTORY: begin
              q_nxt.start     = cmd.addr;
              q_nxt.busy_bank = cmd.addr[`BANK_HI:`BANK_LO];
              q_nxt.state     = S_FP_CONFIRM;
            end
            default: ;
          endcase
        end
        S_PG_DATA: begin
          q_nxt.cur        = cmd;
          q_nxt.op         = OP_SINGLE;
          q_nxt.slow       = 1'b0;
          q_nxt.prog_valid = 1'b1;
          q_nxt.busy_bank  = cmd.addr[`BANK_HI:`BANK_LO];
          q_nxt.modes[cmd.addr[`BANK_HI:`BANK_LO]] = MODE_STATUS;
          q_nxt.state      = S_WAIT;
        end
        S_BP_COUNT: begin
          if (cmd_blk != q_r.start[`BLOCK_HI:`BLOCK_LO] ||
              cmd.data > {11'h000, `MAX_COUNT_N}) begin
            q_nxt.err[`SR_PROG_ERR]  = 1'b1;
            q_nxt.err[`SR_ERASE_ERR] = 1'b1;
            q_nxt.state              = S_IDLE;
          end else begin
            q_nxt.count  = cmd.data[`BUF_IDX_HI:0];
            q_nxt.loaded = '0;
            q_nxt.state  = S_BP_LOAD;
          end
        end
        S_BP_LOAD: begin
          // The first loaded word fixes the start address of the range
          if (q_r.loaded == '0) begin
            q_nxt.start = cmd.addr;
          end
          if (cmd_blk != q_r.start[`BLOCK_HI:`BLOCK_LO] ||
              (q_r.loaded != '0 &&
               offs > {18'h00000, q_r.count})) begin
            q_nxt.err[`SR_PROG_ERR]  = 1'b1;
            q_nxt.err[`SR_ERASE_ERR] = 1'b1;
            buf_flush                = 1'b1;
            q_nxt.state              = S_IDLE;
          end else begin
            buf_push     = 1'b1;
            q_nxt.loaded = q_r.loaded + 1'b1;
            if (q_r.loaded == q_r.count) begin
              q_nxt.state = S_BP_CONFIRM;
            end
          end
        end
        S_BP_CONFIRM: begin
          if (code != `CMD_CONFIRM) begin
            q_nxt.err[`SR_PROG_ERR]  = 1'b1;
            q_nxt.err[`SR_ERASE_ERR] = 1'b1;
            buf_flush                = 1'b1;
            q_nxt.state              = S_IDLE;
          end else if (block_locked_in) begin
            q_nxt.err[`SR_PROG_ERR]    = 1'b1;
            q_nxt.err[`SR_PROTECT_ERR] = 1'b1;
            buf_flush                  = 1'b1;
            q_nxt.state                = S_IDLE;
          end else begin
            q_nxt.op    = OP_BUFFER;
            q_nxt.slow  = (q_r.start[`BUF_IDX_HI:0] != '0);
            q_nxt.state = S_RUN;
          end
        end
        S_FP_CONFIRM: begin
          q_nxt.modes[q_r.busy_bank] = MODE_STATUS;
          if (code == `CMD_CONFIRM && !block_locked_in &&
              high_program_supply_level_in &&
              q_r.start[`BUF_IDX_HI:0] == '0) begin
            q_nxt.op    = OP_FACTORY;
            q_nxt.slow  = 1'b0;
            q_nxt.base  = q_r.start;
            q_nxt.idx   = '0;
            q_nxt.state = S_FP_LOAD;
          end else begin
            q_nxt.err[`SR_PROG_ERR] = 1'b1;
            q_nxt.state             = S_IDLE;
          end
        end
        S_FP_LOAD: begin
          // Every in-block word here is data, a status command included
          if (cmd_blk != q_r.start[`BLOCK_HI:`BLOCK_LO]) begin
            buf_flush   = 1'b1;
            q_nxt.state = S_IDLE;
          end else begin
            buf_push      = 1'b1;
            buf_word.addr = q_r.base + {18'h00000, q_r.idx};
            q_nxt.idx     = q_r.idx + 1'b1;
            if (q_r.idx == `LAST_BUF_IDX) begin
              q_nxt.state = S_RUN;
            end
          end
        end
        S_RUN,
        S_WAIT: begin
          // Only mode changes get through while a program runs
          if (rd_cmd) begin
            unique case (code)
              `CMD_RD_ARRAY:  q_nxt.modes[cmd.addr[`BANK_HI:`BANK_LO]] = MODE_ARRAY;
              `CMD_RD_STATUS: q_nxt.modes[cmd.addr[`BANK_HI:`BANK_LO]] = MODE_STATUS;
              `CMD_RD_SIG,
              `CMD_RD_QUERY:  q_nxt.modes[cmd.addr[`BANK_HI:`BANK_LO]] = MODE_AUX;
              default: ;
            endcase
          end
        end
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // Program engine; its error sets follow the clear above
    // ----------------------------------------------------------------
    unique case (q_r.state)
      S_RUN: begin
        if (buf_valid) begin
          buf_pop          = 1'b1;
          q_nxt.cur        = buf_out;
          q_nxt.retry      = '0;
          q_nxt.prog_valid = 1'b1;
          q_nxt.state      = S_WAIT;
        end else if (q_r.op == OP_FACTORY) begin
          q_nxt.base  = q_r.base + `BUF_STEP;
          q_nxt.idx   = '0;
          q_nxt.state = S_FP_LOAD;
        end else begin
          q_nxt.state = S_IDLE;
        end
      end
      S_WAIT: begin
        if (prog_done_in) begin
          if (prog_fail_in && q_r.op == OP_FACTORY &&
              q_r.retry != `FP_RETRY_MAX) begin
            q_nxt.retry = q_r.retry + 1'b1;
          end else if (prog_fail_in) begin
            q_nxt.prog_valid        = 1'b0;
            q_nxt.err[`SR_PROG_ERR] = 1'b1;
            buf_flush               = 1'b1;
            q_nxt.state             = S_IDLE;
          end else begin
            q_nxt.prog_valid = 1'b0;
            q_nxt.state      = (q_r.op == OP_SINGLE) ? S_IDLE : S_RUN;
          end
        end
      end
      default: ;
    endcase

    // ----------------------------------------------------------------
    // Reset pin: filtered, then abort
    // ----------------------------------------------------------------
    q_nxt.rp_sync = {q_r.rp_sync[1:0], reset_pin_low_active_in};
    if (q_r.rp_sync[1] == q_r.rp_sync[2]) begin
      q_nxt.rp_lvl = q_r.rp_sync[2];
    end
    if (!q_r.rp_lvl) begin
      q_nxt.state      = S_IDLE;
      q_nxt.prog_valid = 1'b0;
      q_nxt.modes      = '0;
      q_nxt.err        = '0;
      buf_flush        = 1'b1;
    end

    // Status word as the host will see it next cycle
    q_nxt.busy = (q_nxt.state == S_RUN) || (q_nxt.state == S_WAIT) ||
                 (q_nxt.state == S_FP_LOAD);
    q_nxt.stat_o = q_nxt.err;
    q_nxt.stat_o[`SR_READY] = (q_nxt.state != S_RUN) &&
                              (q_nxt.state != S_WAIT);
    q_nxt.stat_o[`SR_BANK_WR_RDY] = (q_nxt.state == S_FP_LOAD) ? buf_ready :
                                    q_nxt.stat_o[`SR_READY];
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_r         <= '0;
      q_r.stat_o  <= `SR_RESET_VALUE;
      q_r.rp_sync <= 3'h7;
      q_r.rp_lvl  <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_valid_out   = q_r.rd_valid;
  assign rd_data_out    = q_r.rd_data;
  assign prog_valid_out = q_r.prog_valid;
  assign prog_addr_out  = q_r.cur.addr;
  assign prog_data_out  = q_r.cur.data;
  assign prog_slow_out  = q_r.slow;
  assign status_out     = q_r.stat_o;
  assign busy_out       = q_r.busy;
  assign lock_block_out = q_r.start[`BLOCK_HI:`BLOCK_LO];

endmodule

// ===== rtl/fsq_consts.svh
// Constants of the flash program sequencer: geometry, command codes,
// status bit positions and counts.
// Assumes inclusion by its bare name from the package and the modules.
`ifndef FSQ_CONSTS_SVH
`define FSQ_CONSTS_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define ADDR_W          23
`define DATA_W          16
`define BANK_HI         22
`define BANK_LO         19
`define BLOCK_HI        22
`define BLOCK_LO        16
`define NUM_BANKS       16
`define BUF_WORDS       32
`define BUF_IDX_HI      4
`define INTAKE_DEPTH    16

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define CMD_PROG_SETUP  8'h40
`define CMD_CLR_STATUS  8'h50
`define CMD_RD_STATUS   8'h70
`define CMD_FACTORY     8'h80
`define CMD_RD_SIG      8'h90
`define CMD_RD_QUERY    8'h98
`define CMD_SUSPEND     8'hb0
`define CMD_CONFIRM     8'hd0
`define CMD_BUF_PROG    8'he8
`define CMD_RD_ARRAY    8'hff

// ----------------------------------------------------------------
// Status bits and counts
// ----------------------------------------------------------------
`define SR_READY        7
`define SR_ERASE_ERR    5
`define SR_PROG_ERR     4
`define SR_PROTECT_ERR  1
`define SR_BANK_WR_RDY  0
`define SR_RESET_VALUE  8'h81
`define MAX_COUNT_N     5'h1f
`define LAST_BUF_IDX    5'h1f
`define BUF_STEP        23'h000020
`define FP_RETRY_MAX    4'h8

`endif

// ===== rtl/fsq_pkg.sv
// Types of the flash program sequencer, including the host write word its FIFOs carry.
// Assumes fsq_consts.svh is on the include path.
`include "fsq_consts.svh"

package fsq_pkg;

  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] data;
  } host_write_t;

  typedef enum logic [3:0] {
    S_IDLE, S_PG_DATA, S_BP_COUNT, S_BP_LOAD, S_BP_CONFIRM,
    S_FP_CONFIRM, S_FP_LOAD, S_RUN, S_WAIT
  } seq_state_t;

  typedef enum logic [1:0] {MODE_ARRAY, MODE_STATUS, MODE_AUX} read_mode_t;

  typedef enum logic [1:0] {OP_SINGLE, OP_BUFFER, OP_FACTORY} op_t;

  typedef struct packed {
    seq_state_t                    state;
    op_t                           op;
    read_mode_t [`NUM_BANKS-1:0]   modes;
    logic [7:0]                    err;
    logic [7:0]                    stat_o;
    logic [`BANK_HI-`BANK_LO:0]    busy_bank;
    logic [`ADDR_W-1:0]            start;
    logic [`ADDR_W-1:0]            base;
    logic [`BUF_IDX_HI:0]          count;
    logic [`BUF_IDX_HI:0]          loaded;
    logic [`BUF_IDX_HI:0]          idx;
    logic [3:0]                    retry;
    host_write_t                   cur;
    logic                          prog_valid;
    logic                          slow;
    logic                          busy;
    logic                          rd_valid;
    logic [`DATA_W-1:0]            rd_data;
    logic [2:0]                    rp_sync;
    logic                          rp_lvl;
  } seq_regs_t;

endpackage

// ===== rtl/word_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a flush.
// Assumes one clock; ready and valid flags come from flip-flops.
`timescale 1ns/100ps

module word_fifo #(
  parameter int WIDTH = 39,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  input  wire logic             flush_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW:0]      cnt_r;
  logic [PW:0]      cnt_nxt;
  logic             push;
  logic             pop;

  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;
  assign out_data_out = mem[rd_ptr_r];

  always_comb begin
    cnt_nxt = cnt_r;
    if (flush_in) begin
      cnt_nxt = '0;
    end else if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_r      <= '0;
      rd_ptr_r      <= '0;
      cnt_r         <= '0;
      in_ready_out  <= 1'b0;
      out_valid_out <= 1'b0;
    end else begin
      cnt_r         <= cnt_nxt;
      in_ready_out  <= (cnt_nxt != (PW+1)'(DEPTH));
      out_valid_out <= (cnt_nxt != '0);
      if (flush_in) begin
        wr_ptr_r <= '0;
        rd_ptr_r <= '0;
      end else begin
        if (push) begin
          wr_ptr_r <= (wr_ptr_r == PW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
        end
        if (pop) begin
          rd_ptr_r <= (rd_ptr_r == PW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
        end
      end
    end
  end

  // Storage carries no reset so it can map onto RAM
  always_ff @(posedge sys_clk_in) begin
    if (push && !flush_in) begin
      mem[wr_ptr_r] <= in_data_in;
    end
  end

endmodule
